// ==== supply_supervisor_watchdog.v ====
// Supply supervisor: rail, lockout, manual reset and watchdog driven reset output
`timescale 1ns/1ps
`include "supervisor_defs.vh"
module supply_supervisor_watchdog #(
  parameter WDT_W         = 26,
  parameter HOLD_W        = 23,
  parameter MR_CNT_W      = 16,
  parameter WDT_SHORT_CYC = `WDT_SHORT_CYC,
  parameter WDT_LONG_CYC  = `WDT_LONG_CYC,
  parameter HOLD_CYC      = `HOLD_CYC,
  parameter MR_DEB_CYC    = `MR_DEBOUNCE_CYC
) (
  sys_clk,
  rstn,
  threshold_below,
  supply_below_uvlo,
  manual_reset_in_n,
  watchdog_kick_in,
  kick_valid,
  wdt_long_sel,
  reset_out_n_o,
  reset_out_n_oe,
  reset_active
);
  input               sys_clk;
  input               rstn;
  // Comparator: threshold_sense_in below the reset_trip_level reference
  input               threshold_below;
  // Comparator: analog_supply_in below the factory lockout level
  input               supply_below_uvlo;
  input               manual_reset_in_n;
  input               watchdog_kick_in;
  input               kick_valid;
  input               wdt_long_sel;
  output              reset_out_n_o;
  output              reset_out_n_oe;
  output              reset_active;
  wire                sys_clk;
  wire                rstn;
  wire                threshold_below;
  wire                supply_below_uvlo;
  wire                manual_reset_in_n;
  wire                watchdog_kick_in;
  wire                kick_valid;
  wire                wdt_long_sel;
  reg                 reset_out_n_o;
  reg                 reset_out_n_oe;
  reg                 reset_active;

  ////////////////////////////////////////////////////////////////////////////
  // Manual reset: glitch filter then debounce
  localparam FILT_N = `MR_FILTER_CYC;
  reg  [FILT_N-1:0]   mr_shift_ff;
  reg                 mr_filt_ff;
  wire                mr_clean;

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mr_shift_ff <= {FILT_N{1'b1}};
      mr_filt_ff  <= 1'b1;
    end
    else
    begin
      mr_shift_ff <= {mr_shift_ff[FILT_N-2:0], manual_reset_in_n};
      // Low only when low across the whole glitch window
      if (mr_shift_ff == {FILT_N{1'b0}})
        mr_filt_ff <= 1'b0; // [RULE9]
      else if (mr_shift_ff == {FILT_N{1'b1}})
        mr_filt_ff <= 1'b1;
    end
  end

  // Pull-up view: undriven pin presents high, reset value high [RULE10]
  level_debouncer #(
    .CNT_W     (MR_CNT_W),
    .STABLE_CY (MR_DEB_CYC),
    .RST_VAL   (1'b1)
  ) u_mr_deb (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .raw_in    (mr_filt_ff),
    .clean_out (mr_clean)
  ); // [RULE8]

  ////////////////////////////////////////////////////////////////////////////
  // Kick edge detection
  reg                 kick_q_ff;
  reg                 kick_en_ff;
  wire                kick_edge;

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      kick_q_ff  <= 1'b0;
      kick_en_ff <= 1'b0;
    end
    else
    begin
      kick_q_ff  <= watchdog_kick_in;
      kick_en_ff <= kick_valid;
    end
  end

  // Either polarity; 80 ns spans two samples so a pulse is seen [RULE11] [RULE12]
  assign kick_edge = (watchdog_kick_in != kick_q_ff) | (kick_valid != kick_en_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Reset sources
  wire                rail_low;
  wire                hard_hold;
  assign rail_low  = threshold_below; // [RULE4]
  // Held low as long as any level source is active [RULE2] [RULE5] [RULE6]
  assign hard_hold = rail_low | supply_below_uvlo | ~mr_clean;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  reg  [1:0]          state_ff;
  reg  [1:0]          nxt_state;
  reg  [HOLD_W-1:0]   hold_cnt_ff;
  reg  [HOLD_W-1:0]   nxt_hold_cnt;
  reg  [WDT_W-1:0]    wdt_cnt_ff;
  reg  [WDT_W-1:0]    nxt_wdt_cnt;
  wire [WDT_W-1:0]    wdt_limit;
  wire                wdt_expire;
  // Last counts cut to counter width on purpose
  localparam integer      HOLD_LAST_I = HOLD_CYC - 1;
  localparam integer      WDT_SHORT_I = WDT_SHORT_CYC - 1;
  localparam integer      WDT_LONG_I  = WDT_LONG_CYC - 1;
  localparam [HOLD_W-1:0] HOLD_LAST   = HOLD_LAST_I[HOLD_W-1:0];
  localparam [WDT_W-1:0]  WDT_SHORT   = WDT_SHORT_I[WDT_W-1:0];
  localparam [WDT_W-1:0]  WDT_LONG    = WDT_LONG_I[WDT_W-1:0];
  localparam [1:0]        ST_HOLD     = `ST_HOLD;
  localparam [1:0]        ST_RUN      = `ST_RUN;

  // Factory timeout choice, both lengths are parameters [RULE18] [RULE19]
  assign wdt_limit  = wdt_long_sel ? WDT_LONG : WDT_SHORT;
  // Disabled while the kick pin is floating [RULE17] [RULE20]
  assign wdt_expire = kick_valid & (wdt_cnt_ff >= wdt_limit) & ~kick_edge; // [RULE13]

  always @*
  begin
    nxt_state    = state_ff;
    nxt_hold_cnt = hold_cnt_ff;
    nxt_wdt_cnt  = wdt_cnt_ff;
    case (state_ff)
      ST_HOLD:
      begin
        // Counter frozen at zero while reset is asserted [RULE15] [RULE16]
        nxt_wdt_cnt = {WDT_W{1'b0}};
        if (hard_hold)
          nxt_hold_cnt = {HOLD_W{1'b0}};
        else if (hold_cnt_ff >= HOLD_LAST)
        begin
          nxt_state    = ST_RUN;
          nxt_hold_cnt = {HOLD_W{1'b0}};
        end
        else
          nxt_hold_cnt = hold_cnt_ff + 1'b1; // [RULE3] [RULE7]
      end
      ST_RUN:
      begin
        nxt_hold_cnt = {HOLD_W{1'b0}};
        if (hard_hold | wdt_expire)
        begin
          nxt_state   = ST_HOLD; // [RULE2] [RULE13]
          nxt_wdt_cnt = {WDT_W{1'b0}};
        end
        else if (kick_edge | ~kick_valid)
          nxt_wdt_cnt = {WDT_W{1'b0}}; // [RULE11]
        else
          nxt_wdt_cnt = wdt_cnt_ff + 1'b1;
      end
      default:
      begin
        nxt_state    = ST_HOLD;
        nxt_hold_cnt = {HOLD_W{1'b0}};
        nxt_wdt_cnt  = {WDT_W{1'b0}};
      end
    endcase
  end

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_ff    <= ST_HOLD;
      hold_cnt_ff <= {HOLD_W{1'b0}};
      wdt_cnt_ff  <= {WDT_W{1'b0}};
    end
    else
    begin
      state_ff    <= nxt_state;
      hold_cnt_ff <= nxt_hold_cnt;
      wdt_cnt_ff  <= nxt_wdt_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain output: drive low only when asserting
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reset_out_n_o  <= 1'b0;
      reset_out_n_oe <= 1'b1;
      reset_active   <= 1'b1;
    end
    else
    begin
      reset_out_n_o  <= 1'b0; // [RULE1]
      reset_out_n_oe <= (nxt_state == ST_HOLD); // [RULE1]
      reset_active   <= (nxt_state == ST_HOLD);
    end
  end
endmodule // supply_supervisor_watchdog

// ==== supervisor_defs.vh ====
// Timing constants and encodings for the supply supervisor and watchdog
// Operation
// RULE1: Reset output is active low open drain: pull low to assert, release otherwise.
// RULE2: Assert reset whenever the monitored rail is below the trip level.
// RULE3: Hold reset for the hold time after rail recovery or watchdog expiry.
// RULE4: Sense below the 0.5 V reference means the rail is under threshold.
// RULE5: Assert reset at once while supply sits below the chosen lockout level.
// RULE6: Assert reset as long as manual reset input is held low.
// RULE7: On manual reset release, hold reset for the hold time before release.
// RULE8: Debounce the manual reset input so a pushbutton gives a clean request.
// RULE9: Ignore low glitches on manual reset up to about 100 ns.
// RULE10: An unconnected manual reset input counts as high, no request.
// RULE11: Clear the watchdog counter on every rising or falling kick edge.
// RULE12: Kick pulses as short as 80 ns count as valid clearing edges.
// RULE13: Assert reset when the watchdog counter reaches the timeout uncleared.
// RULE14: The host must toggle the kick input faster than the watchdog timeout.
// RULE15: Clear the watchdog counter when reset comes from rail undervoltage.
// RULE16: Hold the watchdog counter at zero while reset is asserted.
// RULE17: A floating or high impedance kick input disables the watchdog.
// RULE18: A factory select chooses between two watchdog timeout durations.
// RULE19: Watchdog timeout and reset hold time are configuration parameters.
// RULE20: A valid flag from an outside detector gates the watchdog on.
`ifndef SUPERVISOR_DEFS_VH
`define SUPERVISOR_DEFS_VH
`define CLK_PERIOD_NS        40
`define MR_GLITCH_NS         100
`define KICK_MIN_PULSE_NS    80
// Glitch filter length, rounded up, plus one for margin
`define MR_FILTER_CYC        ((`MR_GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1)
// Debounce settle window in cycles (1 ms at 25 MHz)
`define MR_DEBOUNCE_CYC      25000
`define WDT_SHORT_CYC        25000000
`define WDT_LONG_CYC         40000000
`define HOLD_CYC             5000000
`define ST_HOLD              2'h0
`define ST_RUN               2'h1
`endif

// ==== level_debouncer.v ====
// Debounce filter: output follows input once stable for a set count
`timescale 1ns/1ps
`include "supervisor_defs.vh"
module level_debouncer #(
  parameter CNT_W     = 16,
  parameter STABLE_CY = `MR_DEBOUNCE_CYC,
  parameter RST_VAL   = 1'b1
) (
  sys_clk,
  rstn,
  raw_in,
  clean_out
);
  input              sys_clk;
  input              rstn;
  input              raw_in;
  output             clean_out;
  wire               sys_clk;
  wire               rstn;
  wire               raw_in;
  wire               clean_out;
  reg                state_ff;
  reg  [CNT_W-1:0]   cnt_ff;
  reg  [CNT_W-1:0]   nxt_cnt;
  reg                nxt_state;
  // Cut to counter width on purpose
  localparam integer     LIMIT_I = STABLE_CY - 1;
  localparam [CNT_W-1:0] LIMIT   = LIMIT_I[CNT_W-1:0];

  always @*
  begin
    nxt_state = state_ff;
    nxt_cnt   = {CNT_W{1'b0}};
    if (raw_in != state_ff)
    begin
      if (cnt_ff >= LIMIT)
        nxt_state = raw_in;
      else
        nxt_cnt = cnt_ff + 1'b1;
    end
  end

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_ff <= RST_VAL;
      cnt_ff   <= {CNT_W{1'b0}};
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  assign clean_out = state_ff;
endmodule // level_debouncer

// ==== supervisor_checker.sv ====
// Assertion checker for the supply supervisor reset output
`timescale 1ns/1ps
module supervisor_checker #(
  parameter WDT_SHORT_CYC = 50,
  parameter WDT_LONG_CYC  = 80
) (
  input logic sys_clk,
  input logic rstn,
  input logic threshold_below,
  input logic supply_below_uvlo,
  input logic manual_reset_in_n,
  input logic watchdog_kick_in,
  input logic kick_valid,
  input logic wdt_long_sel,
  input logic reset_out_n_o,
  input logic reset_out_n_oe,
  input logic reset_active
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic [31:0] idle_ff;
  logic        kick_ff;
  logic [31:0] lim;
  assign lim = wdt_long_sel ? WDT_LONG_CYC : WDT_SHORT_CYC;
  // Cycles without a kick while the watchdog may run
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      idle_ff <= 32'h0;
      kick_ff <= 1'b0;
    end
    else
    begin
      kick_ff <= watchdog_kick_in;
      idle_ff <= (reset_active || !kick_valid || watchdog_kick_in != kick_ff) ? 32'h0
                 : idle_ff + 32'h1;
    end
  end
  a_od_data_low: assert property (reset_out_n_o == 1'b0)
    else $error("reset data not low");
  a_oe_tracks: assert property (reset_out_n_oe == reset_active)
    else $error("enable differs");
  a_rail_asserts: assert property (threshold_below |=> reset_active)
    else $error("rail low no reset");
  a_uvlo_asserts: assert property (supply_below_uvlo |=> reset_active)
    else $error("lockout no reset");
  a_rail_hold: assert property ($fell(threshold_below) |-> reset_active [*8])
    else $error("rail hold short");
  a_mr_hold: assert property ($rose(manual_reset_in_n) && reset_active |-> reset_active [*8])
    else $error("manual hold short");
  a_glitch_ignored: assert property ((!reset_active && !kick_valid && !threshold_below
    && !supply_below_uvlo && $fell(manual_reset_in_n)) ##1 !manual_reset_in_n
    ##1 manual_reset_in_n |=> !reset_active [*4]) else $error("glitch caused reset");
  a_wdt_bound: assert property (idle_ff <= lim + 32'h1)
    else $error("watchdog overran");
  a_wdt_off: assert property (!reset_active && !kick_valid && !threshold_below
    && !supply_below_uvlo && manual_reset_in_n |=> !reset_active) else $error("idle reset");
  c_wdt_expire: cover property (idle_ff == lim - 32'h1);
  c_mr_press: cover property ($rose(reset_active) && !manual_reset_in_n);
  c_release: cover property ($fell(reset_active));
endmodule // supervisor_checker
bind supply_supervisor_watchdog supervisor_checker #(.WDT_SHORT_CYC(WDT_SHORT_CYC),
  .WDT_LONG_CYC(WDT_LONG_CYC)) u_chk (.sys_clk(sys_clk), .rstn(rstn),
  .threshold_below(threshold_below), .supply_below_uvlo(supply_below_uvlo),
  .manual_reset_in_n(manual_reset_in_n), .watchdog_kick_in(watchdog_kick_in),
  .kick_valid(kick_valid), .wdt_long_sel(wdt_long_sel), .reset_out_n_o(reset_out_n_o),
  .reset_out_n_oe(reset_out_n_oe), .reset_active(reset_active));

// ==== host_cpu_model.sv ====
// Host processor model: strobes the watchdog kick while running
`timescale 1ns/1ps
module host_cpu_model (
  input  wire logic       sys_clk,
  input  wire logic       reset_line,
  input  wire logic       kick_en,
  input  wire logic [7:0] gap,
  output logic            kick
);
  logic [7:0] cnt_ff = 8'h00;
  initial kick = 1'b0;
  // Two-cycle pulse every gap+1 cycles, silent while held in reset
  always @(negedge sys_clk)
  begin
    cnt_ff <= (!reset_line || !kick_en || cnt_ff == gap) ? 8'h00 : cnt_ff + 8'h01;
    kick <= kick_en && reset_line && cnt_ff >= gap - 8'h01;
  end
endmodule // host_cpu_model

// ==== supply_supervisor_watchdog_tb.sv ====
// Testbench for the supply supervisor and watchdog
`timescale 1ns/1ps
module supply_supervisor_watchdog_tb;
  localparam HOLD = 20;
  localparam WS = 50;
  localparam WL = 80;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic thr = 1'b0;
  logic uvlo = 1'b0;
  logic mr_n = 1'b1;
  logic kv = 1'b0;
  logic sel = 1'b0;
  logic ken = 1'b0;
  wire  kick, o, oe, act;
  wire  reset_line = oe ? o : 1'b1;
  int   n_mismatch = 0;
  int   checks_done = 0;
  int   cycles = 0;
  initial forever #20 sys_clk = ~sys_clk;
  supply_supervisor_watchdog #(.HOLD_CYC(HOLD), .WDT_SHORT_CYC(WS), .WDT_LONG_CYC(WL),
    .MR_DEB_CYC(8)) u_dut (.sys_clk(sys_clk), .rstn(rstn), .threshold_below(thr),
    .supply_below_uvlo(uvlo), .manual_reset_in_n(mr_n), .watchdog_kick_in(kick),
    .kick_valid(kv), .wdt_long_sel(sel), .reset_out_n_o(o), .reset_out_n_oe(oe),
    .reset_active(act));
  host_cpu_model u_host (.sys_clk(sys_clk), .reset_line(reset_line), .kick_en(ken),
    .gap(8'h1E), .kick(kick));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Cycles until reset reaches lvl, bounded
  task automatic wait_lvl(input logic lvl, output int c);
    c = 0;
    while (act !== lvl && c < 200)
    begin
      cyc(1);
      c++;
    end
  endtask
  task automatic t_level(input bit uv);
    int c;
    thr = !uv;
    uvlo = uv;
    cyc(1);
    check(act, 1);
    check(reset_line, 0);
    cyc(30);
    check(act, 1);
    thr = 0;
    uvlo = 0;
    wait_lvl(0, c);
    check(c >= HOLD && c <= HOLD + 2, 1);
    check(reset_line, 1);
    $display("level test %0d done", uv);
  endtask
  task automatic t_mr();
    int c;
    mr_n = 0;
    cyc(2);
    mr_n = 1;
    cyc(12);
    check(act, 0);
    mr_n = 0;
    cyc(30);
    check(act, 1);
    mr_n = 1;
    wait_lvl(0, c);
    check(c >= HOLD && c <= HOLD + 20, 1);
    $display("manual reset test done");
  endtask
  task automatic t_kick();
    kv = 1;
    ken = 1;
    cyc(300);
    check(act, 0);
    kv = 0;
    ken = 0;
    cyc(200);
    check(act, 0);
    $display("kick test done");
  endtask
  task automatic t_wdt(input bit s, input int w);
    int c;
    sel = s;
    kv = 1;
    // Part-run the counter so the rail reset must clear it
    cyc(30);
    thr = 1;
    cyc(5);
    thr = 0;
    wait_lvl(0, c);
    wait_lvl(1, c);
    check(c >= w - 1 && c <= w + 2, 1);
    wait_lvl(0, c);
    check(c >= HOLD && c <= HOLD + 2, 1);
    kv = 0;
    $display("watchdog test %0d done", s);
  endtask
  // Mid-run reset: output asserted at once, then a full hold
  task automatic t_rst();
    int c;
    rstn = 0;
    cyc(2);
    check(act, 1);
    check(reset_line, 0);
    rstn = 1;
    wait_lvl(0, c);
    check(c >= HOLD && c <= HOLD + 2, 1);
    $display("reset test done");
  endtask
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles > 3000)
    begin
      n_mismatch++;
      finish_test();
    end
  end
  initial
  begin
    int c;
    cyc(6);
    rstn = 1;
    wait_lvl(0, c);
    t_level(0);
    t_level(1);
    t_mr();
    t_kick();
    t_rst();
    t_wdt(0, WS);
    t_wdt(1, WL);
    finish_test();
  end
endmodule // supply_supervisor_watchdog_tb
